/* File: core/gcgc_pkg.sv */
// Shared constants and types for the gated counter with gate control
package gcgc_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] GATE_OFS = 8'h04;
  localparam logic [7:0] COUNT_OFS = 8'h08;
  localparam logic [7:0] FLAGS_OFS = 8'h0C;
  localparam logic [7:0] IEN_OFS = 8'h10;

  // ==========================================================
  // Field positions
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_SYNCDIS_BIT = 2;
  localparam int CTRL_CS_LSB = 6;
  localparam int GATE_SRC_LSB = 0;
  localparam int GATE_LVL_BIT = 2;
  localparam int GATE_ARM_BIT = 3;
  localparam int GATE_SPM_BIT = 4;
  localparam int GATE_TGL_BIT = 5;
  localparam int GATE_POL_BIT = 6;
  localparam int GATE_EN_BIT = 7;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_GEV_BIT = 1;
  localparam int IEN_OVF_BIT = 0;
  localparam int IEN_GEV_BIT = 1;
  localparam int IEN_PIE_BIT = 2;
  localparam int IEN_GIE_BIT = 3;

  // ==========================================================
  // Counts and reset values
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  localparam logic [7:0] TMR8_TOP = 8'hFF;
  localparam logic [7:0] TMR8_ZERO = 8'h00;
  localparam logic [1:0] CS_EXTERNAL = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SRC_PIN = 2'b00,
    SRC_TMR8 = 2'b01,
    SRC_CMP = 2'b10,
    SRC_RSVD = 2'b11
  } gcgc_src_type;

  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_WAIT = 2'b01,
    SP_RUN = 2'b10
  } gcgc_sp_type;

  typedef struct packed {
    logic en;
    logic pol;
    logic tgl;
    logic spm;
    logic [1:0] src;
  } gcgc_gate_cfg_type;

  typedef struct packed {
    logic ovf_ie;
    logic gev_ie;
    logic pie;
    logic global_irq_enable;
  } gcgc_ien_type;

endpackage : gcgc_pkg

/* File: core/gcgc_gate_counter.sv */
// Gated 16-bit up-counter with gate control, AHB-Lite register slave
//
// Notes on behaviour
// - Gate qualifies counting only while gate_enable_bit is set.
// - Polarity 0 counts on low gate, polarity 1 counts on high gate.
// - Active gate increments count_pair per counter_clock rising edge; inactive holds.
// - Gate source 00 pin, 01 timer overflow, 10 comparator, 11 reserved.
// - 8-bit timer FFh to 00h wrap makes an internal pulse gate source.
// - Toggle mode routes source through flip-flop inverting on each rising edge.
// - With toggle mode off the toggle flip-flop is held at zero.
// - Armed single-pulse counting starts at next rising gate edge.
// - Hardware clears the arm flag on the captured pulse's trailing edge.
// - After completion no gate event counts until software re-arms.
// - Toggle and single-pulse modes work together to capture one period.
// - Gate level status is readable and valid with gate disabled.
// - Falling gate level sets gate_event_flag; with its, peripheral and global enables it requests an interrupt.
// - gate_event_flag keeps setting while gate_enable_bit is clear.
// - Count wraps FFFFh to 0000h and each wrap sets overflow_flag.
// - Overflow interrupt needs counter on, overflow, peripheral and global enables.
// - overflow_flag stays set until software clears it.
// - In sleep only asynchronous external counting runs; other modes stop.
// - Overflow in sleep with the wake setup wakes; handler needs global enable.
`timescale 1ns/1ns
module gcgc_gate_counter (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic gate_input_pin,
  input wire logic comparator_sync_out,
  input wire logic [7:0] timer_count,
  input wire logic external_clock_pin,
  input wire logic sleep_mode,
  output logic irq_req,
  output logic wake_req,
  output logic gate_level_status
);

  // ==========================================================
  // Helpers
  function automatic logic rise(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction : rise

  function automatic logic fall(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction : fall

  // ==========================================================
  // State
  logic on_q, syncdis_q;
  logic [1:0] cs_q;
  gcgc_pkg::gcgc_gate_cfg_type cfg_q;
  gcgc_pkg::gcgc_ien_type ien_q;
  logic arm_q, arm_d;
  logic [15:0] cnt_q, cnt_d;
  logic ovf_flag_q, gev_flag_q;
  logic gpin_s1_q, gpin_s2_q, cmp_s1_q, cmp_s2_q, tck_s1_q, tck_s2_q, tck_prev_q;
  logic [7:0] tmr_prev_q;
  logic ovf8_q;
  logic src_prev_q, tff_q, tff_d, lvl_prev_q, gval_q;
  gcgc_pkg::gcgc_sp_type sp_q, sp_d;
  logic wr_q;
  logic [7:0] waddr_q;
  logic hreadyout_q, hresp_q, irq_q, wake_q;
  logic [31:0] hrdata_q;

  // ==========================================================
  // Bus decode
  wire ap_take = hsel & htrans[1] & hready;
  wire [7:0] ap_addr = haddr[7:0];
  wire wr_ctrl = wr_q & (waddr_q == gcgc_pkg::CTRL_OFS);
  wire wr_gate = wr_q & (waddr_q == gcgc_pkg::GATE_OFS);
  wire wr_cnt = wr_q & (waddr_q == gcgc_pkg::COUNT_OFS);
  wire wr_flags = wr_q & (waddr_q == gcgc_pkg::FLAGS_OFS);
  wire wr_ien = wr_q & (waddr_q == gcgc_pkg::IEN_OFS);

  // Read words; unmapped addresses read zero, reserved bits zero
  wire [31:0] rd_ctrl = {24'h000000, cs_q, 3'b000, syncdis_q, 1'b0, on_q};
  wire [31:0] rd_gate = {24'h000000, cfg_q.en, cfg_q.pol, cfg_q.tgl, cfg_q.spm,
                         arm_q, gval_q, cfg_q.src};
  wire [31:0] rd_cnt = {16'h0000, cnt_q};
  wire [31:0] rd_flags = {30'h0, gev_flag_q, ovf_flag_q};
  wire [31:0] rd_ien = {28'h0000000, ien_q.global_irq_enable, ien_q.pie, ien_q.gev_ie, ien_q.ovf_ie};
  wire [31:0] rd_word = (ap_addr == gcgc_pkg::CTRL_OFS) ? rd_ctrl :
                        (ap_addr == gcgc_pkg::GATE_OFS) ? rd_gate :
                        (ap_addr == gcgc_pkg::COUNT_OFS) ? rd_cnt :
                        (ap_addr == gcgc_pkg::FLAGS_OFS) ? rd_flags :
                        (ap_addr == gcgc_pkg::IEN_OFS) ? rd_ien : 32'h00000000;

  // Bus phase registers; zero wait states, always OKAY
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b0;
      hresp_q <= 1'b0;
    end else begin
      wr_q <= ap_take & hwrite;
      waddr_q <= ap_addr;
      hrdata_q <= (ap_take & ~hwrite) ? rd_word : hrdata_q;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  // ==========================================================
  // Input synchronisers; stage one feeds only stage two
  always_ff @(posedge clk) begin
    if (srst) begin
      gpin_s1_q <= 1'b0;
      gpin_s2_q <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      tck_s1_q <= 1'b0;
      tck_s2_q <= 1'b0;
      tck_prev_q <= 1'b0;
    end else begin
      gpin_s1_q <= gate_input_pin;
      gpin_s2_q <= gpin_s1_q;
      cmp_s1_q <= comparator_sync_out;
      cmp_s2_q <= cmp_s1_q;
      tck_s1_q <= external_clock_pin;
      tck_s2_q <= tck_s1_q;
      tck_prev_q <= tck_s2_q;
    end
  end

  // ==========================================================
  // Gate path: source, toggle, polarity, single pulse
  wire tmr8_wrap = (tmr_prev_q == gcgc_pkg::TMR8_TOP) &
                   (timer_count == gcgc_pkg::TMR8_ZERO);
  // Reserved source code reads as a low source, closed only with polarity 1
  wire src_w = (cfg_q.src == gcgc_pkg::SRC_PIN) ? gpin_s2_q :
               (cfg_q.src == gcgc_pkg::SRC_TMR8) ? ovf8_q :
               (cfg_q.src == gcgc_pkg::SRC_CMP) ? cmp_s2_q : 1'b0;
  wire src_rise = rise(src_prev_q, src_w);
  wire gsig = cfg_q.tgl ? tff_q : src_w;
  wire lvl_w = cfg_q.pol ? gsig : ~gsig;
  wire lvl_rise = rise(lvl_prev_q, lvl_w);
  wire lvl_fall = fall(lvl_prev_q, lvl_w);
  wire gval_w = cfg_q.spm ? ((sp_q == gcgc_pkg::SP_RUN) & lvl_w) : lvl_w;
  wire gev_set = fall(gval_q, gval_w);

  // Toggle flip-flop forced low when toggle mode is off
  assign tff_d = ~cfg_q.tgl ? 1'b0 : (src_rise ? ~tff_q : tff_q);

  // Single-pulse sequencer; waiting for a fresh edge avoids a partial pulse
  always_comb begin
    sp_d = sp_q;
    case (sp_q)
      gcgc_pkg::SP_IDLE: begin
        if (arm_q & cfg_q.spm) sp_d = gcgc_pkg::SP_WAIT;
      end
      gcgc_pkg::SP_WAIT: begin
        if (~arm_q | ~cfg_q.spm) sp_d = gcgc_pkg::SP_IDLE;
        else if (lvl_rise) sp_d = gcgc_pkg::SP_RUN;
      end
      gcgc_pkg::SP_RUN: begin
        if (~arm_q | ~cfg_q.spm | lvl_fall) sp_d = gcgc_pkg::SP_IDLE;
      end
      default: sp_d = gcgc_pkg::SP_IDLE;
    endcase
  end

  // Arm flag: software write wins over the hardware clear
  wire arm_clr = (sp_q == gcgc_pkg::SP_RUN) & lvl_fall;
  assign arm_d = wr_gate ? hwdata[gcgc_pkg::GATE_ARM_BIT] :
                 (arm_clr ? 1'b0 : arm_q);

  always_ff @(posedge clk) begin
    if (srst) begin
      tmr_prev_q <= 8'h00;
      ovf8_q <= 1'b0;
      src_prev_q <= 1'b0;
      tff_q <= 1'b0;
      lvl_prev_q <= 1'b0;
      gval_q <= 1'b0;
      sp_q <= gcgc_pkg::SP_IDLE;
      arm_q <= 1'b0;
    end else begin
      tmr_prev_q <= timer_count;
      ovf8_q <= tmr8_wrap;
      src_prev_q <= src_w;
      tff_q <= tff_d;
      lvl_prev_q <= lvl_w;
      gval_q <= gval_w;
      sp_q <= sp_d;
      arm_q <= arm_d;
    end
  end

  // ==========================================================
  // Counter; a software write beats a same-cycle increment
  wire ext_clk = (cs_q == gcgc_pkg::CS_EXTERNAL);
  wire tick = ext_clk ? rise(tck_prev_q, tck_s2_q) : 1'b1;
  wire run_ok = ~sleep_mode | (syncdis_q & ext_clk);
  wire inc = on_q & (~cfg_q.en | gval_q) & tick & run_ok;
  wire wrap = inc & ~wr_cnt & (cnt_q == gcgc_pkg::COUNT_TOP);
  assign cnt_d = wr_cnt ? hwdata[15:0] : (inc ? cnt_q + 16'h0001 : cnt_q);

  // Request terms, registered before leaving the block
  wire irq_d = ien_q.global_irq_enable & ien_q.pie &
               ((on_q & ien_q.ovf_ie & ovf_flag_q) |
                (ien_q.gev_ie & gev_flag_q));
  wire wake_d = sleep_mode & on_q & ien_q.ovf_ie & ien_q.pie & syncdis_q & ext_clk &
                ovf_flag_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= gcgc_pkg::COUNT_RST;
      ovf_flag_q <= 1'b0;
      gev_flag_q <= 1'b0;
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      // Write one to clear; a same-cycle set wins
      ovf_flag_q <= wrap | (ovf_flag_q & ~(wr_flags & hwdata[gcgc_pkg::FLAG_OVF_BIT]));
      gev_flag_q <= gev_set | (gev_flag_q & ~(wr_flags & hwdata[gcgc_pkg::FLAG_GEV_BIT]));
      irq_q <= irq_d;
      wake_q <= wake_d;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk) begin
    if (srst) begin
      on_q <= 1'b0;
      syncdis_q <= 1'b0;
      cs_q <= 2'b00;
      cfg_q <= '0;
      ien_q <= '0;
    end else begin
      if (wr_ctrl) begin
        on_q <= hwdata[gcgc_pkg::CTRL_ON_BIT];
        syncdis_q <= hwdata[gcgc_pkg::CTRL_SYNCDIS_BIT];
        cs_q <= hwdata[gcgc_pkg::CTRL_CS_LSB +: 2];
      end
      if (wr_gate) begin
        cfg_q.en <= hwdata[gcgc_pkg::GATE_EN_BIT];
        cfg_q.pol <= hwdata[gcgc_pkg::GATE_POL_BIT];
        cfg_q.tgl <= hwdata[gcgc_pkg::GATE_TGL_BIT];
        cfg_q.spm <= hwdata[gcgc_pkg::GATE_SPM_BIT];
        cfg_q.src <= hwdata[gcgc_pkg::GATE_SRC_LSB +: 2];
      end
      if (wr_ien) begin
        ien_q.ovf_ie <= hwdata[gcgc_pkg::IEN_OVF_BIT];
        ien_q.gev_ie <= hwdata[gcgc_pkg::IEN_GEV_BIT];
        ien_q.pie <= hwdata[gcgc_pkg::IEN_PIE_BIT];
        ien_q.global_irq_enable <= hwdata[gcgc_pkg::IEN_GIE_BIT];
      end
    end
  end

  // ==========================================================
  // Outputs
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign irq_req = irq_q;
  assign wake_req = wake_q;
  assign gate_level_status = gval_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_run_trailing;
    (sp_q == gcgc_pkg::SP_RUN) ##0 lvl_fall;
  endsequence

  chk_count_step: assert property ((inc && !wr_cnt) |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("count did not step");
  chk_gate_hold: assert property ((cfg_q.en && !gval_q && !wr_cnt) |=> $stable(cnt_q))
    else $error("closed gate let count move");
  chk_toggle_clear: assert property (!cfg_q.tgl |=> !tff_q)
    else $error("toggle flop not held low");
  chk_toggle_flip: assert property ((cfg_q.tgl && src_rise) |=> tff_q != $past(tff_q))
    else $error("toggle flop missed edge");
  chk_tmr8_pulse: assert property (tmr8_wrap |=> ovf8_q ##1 !ovf8_q)
    else $error("timer wrap pulse wrong");
  chk_arm_done: assert property ((s_run_trailing and !wr_gate) |=> !arm_q)
    else $error("arm not cleared at trailing edge");
  chk_sp_block: assert property ((cfg_q.spm && sp_q != gcgc_pkg::SP_RUN) |=> !gval_q)
    else $error("single pulse open without arm");
  chk_gev_set: assert property (gev_set |=> gev_flag_q && !gval_q)
    else $error("gate event flag missed");
  chk_ovf_wrap: assert property (wrap |=> ovf_flag_q && cnt_q == 16'h0000)
    else $error("overflow wrap wrong");
  chk_irq_global: assert property (!ien_q.global_irq_enable |=> !irq_q)
    else $error("interrupt without global enable");
  chk_sleep_stop: assert property ((sleep_mode && !run_ok && !wr_cnt) |=> $stable(cnt_q))
    else $error("count moved in sleep");

  // ==========================================================
  // Gate path checks; the pin level check compares against the synchronised source, not the level wire
  sequence s_armed_rise;
    (sp_q == gcgc_pkg::SP_WAIT) ##0 (arm_q && cfg_q.spm && lvl_rise);
  endsequence

  sequence s_plain_pin;
    (!cfg_q.spm && !cfg_q.tgl && cfg_q.src == gcgc_pkg::SRC_PIN);
  endsequence

  chk_sp_start: assert property (s_armed_rise |=> sp_q == gcgc_pkg::SP_RUN)
    else $error("armed sequencer missed gate edge");
  chk_pin_level: assert property (s_plain_pin |=>
    gval_q == ($past(cfg_q.pol) ? $past(gpin_s2_q) : !$past(gpin_s2_q)))
    else $error("gate level does not follow pin and polarity");
  chk_rsvd_closed: assert property ((!cfg_q.spm && !cfg_q.tgl &&
    cfg_q.src == gcgc_pkg::SRC_RSVD) |=> gval_q == !$past(cfg_q.pol))
    else $error("reserved source not closed");
  chk_sync_pipe: assert property ((!srst ##1 !srst) |=>
    gpin_s2_q == $past(gate_input_pin, 2) && cmp_s2_q == $past(comparator_sync_out, 2))
    else $error("synchroniser depth wrong");

  // Counter and flag checks; a software write is left out where it may win
  chk_free_run: assert property ((on_q && !cfg_q.en && tick && run_ok && !wr_cnt) |=>
    cnt_q == $past(cnt_q) + 16'h0001)
    else $error("ungated count did not step");
  chk_ext_hold: assert property ((ext_clk && !rise(tck_prev_q, tck_s2_q) && !wr_cnt) |=>
    $stable(cnt_q))
    else $error("count moved without clock edge");
  chk_ovf_hold: assert property (ovf_flag_q && !(wr_flags &&
    hwdata[gcgc_pkg::FLAG_OVF_BIT]) |=> ovf_flag_q)
    else $error("overflow flag dropped without clear");
  chk_set_wins: assert property ((wrap && wr_flags && hwdata[gcgc_pkg::FLAG_OVF_BIT]) |=> ovf_flag_q)
    else $error("clear beat a same-cycle wrap");
  chk_wake_async: assert property ((!syncdis_q || !ext_clk || !sleep_mode) |=> !wake_q)
    else $error("wake without asynchronous setup");
  chk_bus_okay: assert property (!srst |=> hreadyout_q && !hresp_q)
    else $error("bus not ready or not okay");

endmodule : gcgc_gate_counter

/* File: tb/gcgc_far_side.sv */
// Far-side model: gate pin, comparator output, 8-bit timer and external clock
`timescale 1ns/1ns
module gcgc_far_side (
  input wire logic clk,
  input wire logic pin_set,
  input wire logic cmp_set,
  input wire logic tmr_run,
  input wire logic ext_run,
  output logic gate_input_pin,
  output logic comparator_sync_out,
  output logic [7:0] timer_count,
  output logic external_clock_pin
);
  logic [1:0] div_q = 2'h0;

  initial begin
    gate_input_pin = 1'b0;
    comparator_sync_out = 1'b0;
    timer_count = 8'h00;
    external_clock_pin = 1'b0;
  end

  // ==========================================================
  // Levels follow the bench one edge late; timer wraps FFh to 00h
  always @(posedge clk) begin
    gate_input_pin <= pin_set;
    comparator_sync_out <= cmp_set;
    timer_count <= tmr_run ? timer_count + 8'h01 : timer_count;
    div_q <= ext_run ? div_q + 2'h1 : 2'h0;
    external_clock_pin <= ext_run & div_q[1];  // Stands low between bursts
  end
endmodule : gcgc_far_side

/* File: tb/tb_gcgc_gate_counter.sv */
// Self-checking bench for the gated counter with gate control
`timescale 1ns/1ns
module tb_gcgc_gate_counter;
  localparam logic [7:0] A_CTL = gcgc_pkg::CTRL_OFS;
  localparam logic [7:0] A_GAT = gcgc_pkg::GATE_OFS;
  localparam logic [7:0] A_CNT = gcgc_pkg::COUNT_OFS;
  localparam logic [7:0] A_FLG = gcgc_pkg::FLAGS_OFS;
  localparam logic [7:0] A_IEN = gcgc_pkg::IEN_OFS;
  logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, sleep_mode = 1'b0;
  logic pin_set = 1'b0, cmp_set = 1'b0, tmr_run = 1'b0, ext_run = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, c0;
  logic hreadyout, hresp, irq_req, wake_req, gate_level_status, gpin, gcmp, gext;
  logic [7:0] gtmr;
  logic [31:0] hrdata;
  int n_errors = 0;
  int check_count = 0;

  gcgc_gate_counter gcgc_gate_counter_i (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gate_input_pin(gpin),
    .comparator_sync_out(gcmp), .timer_count(gtmr), .external_clock_pin(gext),
    .sleep_mode(sleep_mode), .irq_req(irq_req), .wake_req(wake_req),
    .gate_level_status(gate_level_status));
  gcgc_far_side gcgc_far_side_i (.clk(clk), .pin_set(pin_set), .cmp_set(cmp_set),
    .tmr_run(tmr_run), .ext_run(ext_run), .gate_input_pin(gpin), .comparator_sync_out(gcmp),
    .timer_count(gtmr), .external_clock_pin(gext));

  // ==========================================================
  // Clock and watchdog
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end

  // ==========================================================
  // Compare, wait and bus tasks
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : chk_flag
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // One single transfer; waits on hready rather than assuming zero wait states
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk_word(rd & m, exp);
  endtask : rd_chk
  task automatic cnt_moves(input logic exp);
    bus(A_CNT, 1'b0, 32'h0);
    c0 = rd;
    cyc(6);
    bus(A_CNT, 1'b0, 32'h0);
    chk_flag(rd !== c0, exp);
  endtask : cnt_moves
  task automatic pulse;
    pin_set <= 1'b1;
    cyc(10);
    pin_set <= 1'b0;
    cyc(10);
  endtask : pulse

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd_chk(A_CTL, 32'hFFFFFFFF, 32'h0);
    rd_chk(A_GAT, 32'hFFFFFFFB, 32'h0);
    rd_chk(A_CNT, 32'hFFFFFFFF, 32'h0);
    rd_chk(A_FLG, 32'hFFFFFFFF, 32'h0);
    rd_chk(A_IEN, 32'hFFFFFFFF, 32'h0);
    rd_chk(8'h20, 32'hFFFFFFFF, 32'h0);
    chk_flag(hresp, 1'b0);
  endtask : t_reset
  task automatic t_gate;
    bus(A_CTL, 1'b1, 32'h1);
    bus(A_GAT, 1'b1, 32'hC0);
    cnt_moves(1'b0);
    pin_set <= 1'b1;
    cyc(6);
    chk_flag(gate_level_status, 1'b1);
    cnt_moves(1'b1);
    bus(A_GAT, 1'b1, 32'h80);
    cnt_moves(1'b0);
    pin_set <= 1'b0;
    cyc(6);
    cnt_moves(1'b1);
    bus(A_GAT, 1'b1, 32'h40);
    cyc(6);
    chk_flag(gate_level_status, 1'b0);
    cnt_moves(1'b1);
    bus(A_CTL, 1'b1, 32'h0);
  endtask : t_gate
  task automatic t_src;
    bus(A_FLG, 1'b1, 32'h3);
    cmp_set <= 1'b1;
    bus(A_GAT, 1'b1, 32'h42);
    cyc(6);
    chk_flag(gate_level_status, 1'b1);
    cmp_set <= 1'b0;
    cyc(6);
    chk_flag(gate_level_status, 1'b0);
    rd_chk(A_FLG, 32'h2, 32'h2);
    bus(A_IEN, 1'b1, 32'hE);
    cyc(2);
    chk_flag(irq_req, 1'b1);
    bus(A_FLG, 1'b1, 32'h2);
    bus(A_IEN, 1'b1, 32'h0);
    pin_set <= 1'b1;
    bus(A_GAT, 1'b1, 32'h43);
    cyc(6);
    chk_flag(gate_level_status, 1'b0);
    pin_set <= 1'b0;
    bus(A_GAT, 1'b1, 32'h41);
    bus(A_FLG, 1'b1, 32'h2);
    rd_chk(A_FLG, 32'h2, 32'h0);
    tmr_run <= 1'b1;
    cyc(300);
    tmr_run <= 1'b0;
    rd_chk(A_FLG, 32'h2, 32'h2);
  endtask : t_src
  task automatic t_tgl;
    bus(A_GAT, 1'b1, 32'hC0);
    bus(A_GAT, 1'b1, 32'hE0);
    pin_set <= 1'b1;
    cyc(6);
    chk_flag(gate_level_status, 1'b1);
    pin_set <= 1'b0;
    cyc(6);
    chk_flag(gate_level_status, 1'b1);
    pin_set <= 1'b1;
    cyc(6);
    chk_flag(gate_level_status, 1'b0);
    pin_set <= 1'b0;
    cyc(6);
    pin_set <= 1'b1;
    cyc(6);
    chk_flag(gate_level_status, 1'b1);
    bus(A_GAT, 1'b1, 32'hC0);
    bus(A_GAT, 1'b1, 32'hE0);
    cyc(6);
    chk_flag(gate_level_status, 1'b0);
    pin_set <= 1'b0;
  endtask : t_tgl
  task automatic t_spm;
    bus(A_FLG, 1'b1, 32'h3);
    bus(A_CTL, 1'b1, 32'h1);
    bus(A_GAT, 1'b1, 32'hD0);
    bus(A_GAT, 1'b1, 32'hD8);
    cnt_moves(1'b0);
    pulse();
    bus(A_CNT, 1'b0, 32'h0);
    chk_flag(rd !== c0, 1'b1);
    rd_chk(A_GAT, 32'h8, 32'h0);
    rd_chk(A_FLG, 32'h2, 32'h2);
    bus(A_CNT, 1'b0, 32'h0);
    c0 = rd;
    pulse();
    rd_chk(A_CNT, 32'hFFFFFFFF, c0);
    bus(A_GAT, 1'b1, 32'hC0);
    bus(A_GAT, 1'b1, 32'hF0);
    bus(A_GAT, 1'b1, 32'hF8);
    pulse();
    rd_chk(A_GAT, 32'h8, 32'h8);
    pulse();
    rd_chk(A_GAT, 32'h8, 32'h0);
    bus(A_GAT, 1'b1, 32'hC0);
  endtask : t_spm
  task automatic t_ovf;
    bus(A_GAT, 1'b1, 32'h0);
    bus(A_CNT, 1'b1, 32'hFFFD);
    bus(A_FLG, 1'b1, 32'h3);
    bus(A_GAT, 1'b1, 32'hC0);
    rd_chk(A_FLG, 32'h1, 32'h1);
    bus(A_CNT, 1'b0, 32'h0);
    chk_flag(rd[15:0] < 16'h0020, 1'b1);
    bus(A_IEN, 1'b1, 32'h5);
    cyc(2);
    chk_flag(irq_req, 1'b0);
    bus(A_IEN, 1'b1, 32'hD);
    cyc(2);
    chk_flag(irq_req, 1'b1);
    bus(A_CTL, 1'b1, 32'h0);
    cyc(2);
    chk_flag(irq_req, 1'b0);
    rd_chk(A_FLG, 32'h1, 32'h1);
    bus(A_FLG, 1'b1, 32'h1);
    rd_chk(A_FLG, 32'h1, 32'h0);
  endtask : t_ovf
  task automatic t_sleep;
    bus(A_GAT, 1'b1, 32'h0);
    bus(A_CTL, 1'b1, 32'h1);
    sleep_mode <= 1'b1;
    cnt_moves(1'b0);
    bus(A_CTL, 1'b1, 32'h0);
    bus(A_CNT, 1'b1, 32'hFFFE);
    bus(A_IEN, 1'b1, 32'h5);
    bus(A_CTL, 1'b1, 32'h85);
    ext_run <= 1'b1;
    cyc(60);
    ext_run <= 1'b0;
    chk_flag(wake_req, 1'b1);
    chk_flag(irq_req, 1'b0);
    bus(A_CTL, 1'b1, 32'h81);
    cyc(2);
    chk_flag(wake_req, 1'b0);
    sleep_mode <= 1'b0;
  endtask : t_sleep

  // ==========================================================
  // Verdict in one place
  task automatic summarize;
    $display("Errors %0d, checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    cyc(12);
    srst <= 1'b0;
    t_reset();
    t_gate();
    t_src();
    t_tgl();
    t_spm();
    t_ovf();
    t_sleep();
    summarize();
  end
endmodule : tb_gcgc_gate_counter
